// ---- rtl/ssp_pkg.sv ----
// Package of constants for the strap and side-pin block.
// Assumes a 50 MHz system clock and a separate pixel clock domain.
package ssp_pkg;

  // ----------------------------------------
  // Serial word layout
  // ----------------------------------------
  localparam int unsigned WORD_W = 32;
  localparam int unsigned AUX_A_BIT = 27;
  localparam int unsigned AUX_B_BIT = 28;
  localparam int unsigned AUDIO_BIT = 29;

  // ----------------------------------------
  // Bit time divisors and spread
  // ----------------------------------------
  localparam logic [5:0] BIT_DIV_HIGH_BW = 6'h1E;
  localparam logic [5:0] BIT_DIV_WIDE = 6'h28;
  localparam int unsigned SPREAD_PERMILLE = 5;

  // ----------------------------------------
  // Bus width strap levels
  // ----------------------------------------
  typedef enum {SSP_BW_OPEN, SSP_BW_HIGH, SSP_BW_BAD} ssp_bw_e;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic STRAP_RST = 1'b0;
  localparam logic [2:0] SYNC_RST = 3'h0;

endpackage : ssp_pkg

// ---- rtl/ssp_strap_side.sv ----
// Strap sampling, side control mapping, interrupt pin and audio pin direction.
// Assumes a pixel clock from the video source and power_down_n as a raw pin.
`timescale 1ns/1ps
module ssp_strap_side
(
  // System
  input wire logic mclk,
  input wire logic rst,
  input wire logic pixClk,
  // Straps and mode pins
  input wire logic powerDown_n,
  input wire logic ctrlProtocolStrap,
  input wire logic spreadEnableStrap,
  input wire logic busWidthHigh,
  input wire logic busWidthLow,
  input wire logic dataRateSelect,
  input wire logic audioEncodeEn,
  input wire logic cryptEn,
  // Pixel side data
  input wire logic [ssp_pkg::WORD_W-1:0] videoWord,
  input wire logic [ssp_pkg::WORD_W-1:0] cryptMask,
  input wire logic auxControlInA,
  input wire logic auxControlInB,
  input wire logic srcControlA,
  input wire logic srcControlB,
  input wire logic srcControlSel,
  // Interrupt registers
  input wire logic irqNewData,
  input wire logic irqRegRead,
  // Audio pins
  input wire logic audioExternal,
  input wire logic recAudioData,
  input wire logic recBitClk,
  input wire logic recWordSel,
  input wire logic audioDataIn,
  input wire logic bitClkIn,
  input wire logic wordSelIn,
  // Display-data channel
  input wire logic displayDataSclIn,
  input wire logic displayDataSdaIn,
  input wire logic ddcSdaDriveLow,
  // Outputs
  output logic [ssp_pkg::WORD_W-1:0] serialWord,
  output logic twoWireMode,
  output logic spreadOn,
  output logic wideMode,
  output logic lowRate,
  output logic [5:0] bitDivisor,
  output logic strapFault,
  output logic irqPendingOut,
  output logic audioDataOut,
  output logic audioDataOe_n,
  output logic bitClkOut,
  output logic bitClkOe_n,
  output logic wordSelOut,
  output logic wordSelOe_n,
  output logic displayDataSclOut,
  output logic displayDataSclOe_n,
  output logic displayDataSdaOut,
  output logic displayDataSdaOe_n,
  output logic ddcSclSeen,
  output logic ddcSdaSeen
);

  // ----------------------------------------
  // Pin synchronisers (mclk domain)
  // ----------------------------------------
  logic [2:0] pdSync;
  logic [2:0] protoSync;
  logic [2:0] ssSync;
  logic [2:0] bwhSync;
  logic [2:0] bwlSync;
  logic [2:0] drsSync;
  logic [2:0] sclSync;
  logic [2:0] sdaSync;
  logic pdStable;
  logic pdPrev;
  logic strapTake;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pdSync <= 3'h0;
      protoSync <= 3'h0;
      ssSync <= 3'h0;
      bwhSync <= 3'h0;
      bwlSync <= 3'h0;
      drsSync <= 3'h0;
      sclSync <= 3'h7;
      sdaSync <= 3'h7;
    end
    else
    begin
      pdSync <= {pdSync[1:0], powerDown_n};
      protoSync <= {protoSync[1:0], ctrlProtocolStrap};
      ssSync <= {ssSync[1:0], spreadEnableStrap};
      bwhSync <= {bwhSync[1:0], busWidthHigh};
      bwlSync <= {bwlSync[1:0], busWidthLow};
      drsSync <= {drsSync[1:0], dataRateSelect};
      sclSync <= {sclSync[1:0], displayDataSclIn};
      sdaSync <= {sdaSync[1:0], displayDataSdaIn};
    end
  end

  // Power-down level counts once stages two and three agree
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pdStable <= 1'b0;
      pdPrev <= 1'b0;
    end
    else
    begin
      if (pdSync[1] == pdSync[2])
        pdStable <= pdSync[2];
      pdPrev <= pdStable;
    end
  end

  // Power-up and wake both show as a rise, as pdStable resets low
  assign strapTake = pdStable && !pdPrev;

  // ----------------------------------------
  // Strap latches
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      twoWireMode <= ssp_pkg::STRAP_RST;
      spreadOn <= ssp_pkg::STRAP_RST;
      wideMode <= ssp_pkg::STRAP_RST;
      strapFault <= ssp_pkg::STRAP_RST;
    end
    else if (strapTake)
    begin
      twoWireMode <= protoSync[2];
      spreadOn <= ssSync[2];
      wideMode <= bwhSync[2];
      strapFault <= bwlSync[2] && !bwhSync[2];
    end
  end

  // Rate select is a live mode pin
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      lowRate <= ssp_pkg::STRAP_RST;
    else if (drsSync[1] == drsSync[2])
      lowRate <= drsSync[2];
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      bitDivisor <= ssp_pkg::BIT_DIV_HIGH_BW;
    else
      bitDivisor <= wideMode ? ssp_pkg::BIT_DIV_WIDE : ssp_pkg::BIT_DIV_HIGH_BW;
  end

  // ----------------------------------------
  // Interrupt pending
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      irqPendingOut <= 1'b0;
    else if (irqNewData)
      irqPendingOut <= 1'b1;
    else if (irqRegRead)
      irqPendingOut <= 1'b0;
  end

  // ----------------------------------------
  // Display-data channel pins
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      displayDataSclOut <= 1'b0;
      displayDataSclOe_n <= 1'b1;
      displayDataSdaOut <= 1'b0;
      displayDataSdaOe_n <= 1'b1;
      ddcSclSeen <= 1'b1;
      ddcSdaSeen <= 1'b1;
    end
    else
    begin
      displayDataSclOut <= 1'b0;
      displayDataSclOe_n <= 1'b1;
      displayDataSdaOut <= 1'b0;
      displayDataSdaOe_n <= !ddcSdaDriveLow;
      if (sclSync[1] == sclSync[2])
        ddcSclSeen <= sclSync[2];
      if (sdaSync[1] == sdaSync[2])
        ddcSdaSeen <= sdaSync[2];
    end
  end

  // ----------------------------------------
  // Pixel clock domain
  // ----------------------------------------
  logic [1:0] pxResetSync;
  logic pxRst;
  logic [2:0] pxCryptSync;
  logic [2:0] pxAudEnSync;
  logic [2:0] pxExtSync;
  logic pxCrypt;
  logic pxAudEn;
  logic pxExt;
  logic [ssp_pkg::WORD_W-1:0] next_serialWord;

  always_ff @(posedge pixClk or posedge rst)
  begin
    if (rst)
      pxResetSync <= 2'h3;
    else
      pxResetSync <= {pxResetSync[0], 1'b0};
  end
  assign pxRst = pxResetSync[1];

  always_ff @(posedge pixClk or posedge rst)
  begin
    if (rst)
    begin
      pxCryptSync <= ssp_pkg::SYNC_RST;
      pxAudEnSync <= ssp_pkg::SYNC_RST;
      pxExtSync <= ssp_pkg::SYNC_RST;
      pxCrypt <= 1'b0;
      pxAudEn <= 1'b0;
      pxExt <= 1'b0;
    end
    else
    begin
      pxCryptSync <= {pxCryptSync[1:0], cryptEn};
      pxAudEnSync <= {pxAudEnSync[1:0], audioEncodeEn};
      pxExtSync <= {pxExtSync[1:0], audioExternal};
      if (pxCryptSync[1] == pxCryptSync[2])
        pxCrypt <= pxCryptSync[2];
      if (pxAudEnSync[1] == pxAudEnSync[2])
        pxAudEn <= pxAudEnSync[2];
      if (pxExtSync[1] == pxExtSync[2])
        pxExt <= pxExtSync[2];
    end
  end

  always_comb
  begin
    next_serialWord = videoWord ^ (pxCrypt ? cryptMask : '0);
    next_serialWord[ssp_pkg::AUX_A_BIT] = srcControlSel ? srcControlA : auxControlInA;
    next_serialWord[ssp_pkg::AUX_B_BIT] = srcControlSel ? srcControlB : auxControlInB;
    if (!pxAudEn)
      next_serialWord[ssp_pkg::AUDIO_BIT] = audioDataIn;
    else if (pxExt)
      next_serialWord[ssp_pkg::AUDIO_BIT] = audioDataIn ^ (pxCrypt & cryptMask[ssp_pkg::AUDIO_BIT]);
    else
      next_serialWord[ssp_pkg::AUDIO_BIT] = recAudioData ^ (pxCrypt & cryptMask[ssp_pkg::AUDIO_BIT]);
  end

  always_ff @(posedge pixClk or posedge rst)
  begin
    if (rst)
      serialWord <= '0;
    else if (pxRst)
      serialWord <= '0;
    else
      serialWord <= next_serialWord;
  end

  // Audio pin directions
  always_ff @(posedge pixClk or posedge rst)
  begin
    if (rst)
    begin
      audioDataOut <= 1'b0;
      audioDataOe_n <= 1'b1;
      bitClkOut <= 1'b0;
      bitClkOe_n <= 1'b1;
      wordSelOut <= 1'b0;
      wordSelOe_n <= 1'b1;
    end
    else
    begin
      audioDataOut <= recAudioData;
      audioDataOe_n <= !(pxAudEn && !pxExt);
      bitClkOut <= recBitClk;
      bitClkOe_n <= pxExt;
      wordSelOut <= recWordSel;
      wordSelOe_n <= pxExt;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_AUX_A_MAP: assert property (@(posedge pixClk) disable iff (rst || pxRst)
    serialWord[ssp_pkg::AUX_A_BIT] == $past(srcControlSel ? srcControlA : auxControlInA))
    else $error("aux A not in bit 27");

  AST_AUX_B_MAP: assert property (@(posedge pixClk) disable iff (rst || pxRst)
    serialWord[ssp_pkg::AUX_B_BIT] == $past(srcControlSel ? srcControlB : auxControlInB))
    else $error("aux B not in bit 28");

  AST_IRQ_SET: assert property (@(posedge mclk) disable iff (rst)
    irqNewData |=> irqPendingOut)
    else $error("interrupt not raised");

  AST_IRQ_CLR: assert property (@(posedge mclk) disable iff (rst)
    irqRegRead && !irqNewData |=> !irqPendingOut)
    else $error("interrupt not cleared on read");

  AST_SPREAD_HOLD: assert property (@(posedge mclk) disable iff (rst)
    !strapTake |=> $stable(spreadOn))
    else $error("spread changed without wake");

  AST_PROTO_HOLD: assert property (@(posedge mclk) disable iff (rst)
    !strapTake |=> $stable(twoWireMode))
    else $error("protocol changed without wake");

  sequence wakeSeq;
    !pdStable ##1 pdStable;
  endsequence

  AST_WAKE_RESAMPLE: assert property (@(posedge mclk) disable iff (rst)
    wakeSeq |=> (twoWireMode == $past(protoSync[2])))
    else $error("protocol not resampled on wake");

  AST_DIVISOR: assert property (@(posedge mclk) disable iff (rst)
    ##1 bitDivisor == ($past(wideMode) ? ssp_pkg::BIT_DIV_WIDE : ssp_pkg::BIT_DIV_HIGH_BW))
    else $error("bit divisor wrong");

  AST_AUDIO_IN: assert property (@(posedge pixClk) disable iff (rst || pxRst)
    !pxAudEn |=> audioDataOe_n)
    else $error("audio pin driven while input");

endmodule : ssp_strap_side

// ---- bench/ssp_src_model.sv ----
// Video source side of the display-data channel.
// Assumes a 50 MHz mclk; resolves both open-drain wires with pull-ups.
`timescale 1ns/1ps
module ssp_src_model
(
  // Clock and control
  input wire logic mclk,
  input wire logic srcRun,
  input wire logic srcSdaLow,
  // Device side of the pins
  input wire logic sclOut,
  input wire logic sclOe_n,
  input wire logic sdaOut,
  input wire logic sdaOe_n,
  // Resolved wires
  output logic sclWire,
  output logic sdaWire
);
  logic srcScl;
  logic [7:0] cnt;
  initial
  begin
    srcScl = 1'b1;
    cnt = 8'h00;
  end
  // 100 kHz clock, idle high between frames
  always @(posedge mclk)
  begin
    if (!srcRun)
    begin
      srcScl <= 1'b1;
      cnt <= 8'h00;
    end
    else if (cnt == 8'hF9)
    begin
      srcScl <= !srcScl;
      cnt <= 8'h00;
    end
    else
      cnt <= cnt + 8'h01;
  end
  assign sclWire = srcScl & (sclOe_n | sclOut);
  assign sdaWire = !srcSdaLow & (sdaOe_n | sdaOut);
endmodule : ssp_src_model

// ---- bench/ssp_strap_side_tb_top.sv ----
// Self-checking bench for the strap and side-pin block.
// Assumes the design package is compiled first.
`timescale 1ns/1ps
module ssp_strap_side_tb_top;
  logic mclk, rst, pixClk, powerDown_n, ctrlProtocolStrap, spreadEnableStrap;
  logic busWidthHigh, busWidthLow, dataRateSelect, audioEncodeEn, cryptEn;
  logic [31:0] videoWord, cryptMask, serialWord, expW;
  logic auxControlInA, auxControlInB, srcControlSel, irqNewData, irqRegRead;
  logic srcControlA, srcControlB;
  logic audioExternal, recAudioData, recBitClk, recWordSel, audioDataIn, bitClkIn, wordSelIn;
  logic ddcSdaDriveLow, srcRun, srcSdaLow, displayDataSclIn, displayDataSdaIn;
  logic twoWireMode, spreadOn, wideMode, lowRate, strapFault, irqPendingOut;
  logic [5:0] bitDivisor;
  logic audioDataOut, audioDataOe_n, bitClkOut, bitClkOe_n, wordSelOut, wordSelOe_n;
  logic displayDataSclOut, displayDataSclOe_n, displayDataSdaOut, displayDataSdaOe_n;
  logic ddcSclSeen, ddcSdaSeen, p, s;
  integer seed, errTotal, checked, i, j;

  ssp_strap_side ssp_strap_side_inst (.mclk, .rst, .pixClk, .powerDown_n, .ctrlProtocolStrap,
    .spreadEnableStrap, .busWidthHigh, .busWidthLow, .dataRateSelect, .audioEncodeEn, .cryptEn,
    .videoWord, .cryptMask, .auxControlInA, .auxControlInB, .srcControlA,
    .srcControlB, .srcControlSel, .irqNewData, .irqRegRead, .audioExternal,
    .recAudioData, .recBitClk, .recWordSel, .audioDataIn, .bitClkIn, .wordSelIn,
    .displayDataSclIn, .displayDataSdaIn, .ddcSdaDriveLow, .serialWord, .twoWireMode,
    .spreadOn, .wideMode, .lowRate, .bitDivisor, .strapFault, .irqPendingOut, .audioDataOut,
    .audioDataOe_n, .bitClkOut, .bitClkOe_n, .wordSelOut, .wordSelOe_n, .displayDataSclOut,
    .displayDataSclOe_n, .displayDataSdaOut, .displayDataSdaOe_n, .ddcSclSeen, .ddcSdaSeen);

  ssp_src_model ssp_src_model_inst (.mclk, .srcRun, .srcSdaLow, .sclOut(displayDataSclOut),
    .sclOe_n(displayDataSclOe_n), .sdaOut(displayDataSdaOut), .sdaOe_n(displayDataSdaOe_n),
    .sclWire(displayDataSclIn), .sdaWire(displayDataSdaIn));

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial
  begin
    pixClk = 1'b0;
    #7;
    // Link clock scaled down; no logic here depends on its rate
    forever #40 pixClk = ~pixClk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked = checked + 1;
    if (g !== e)
    begin
      errTotal = errTotal + 1;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic mc(input int n);
    repeat (n) @(negedge mclk);
  endtask : mc

  task automatic endSim;
    $display("checks %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : endSim

  function automatic logic [5:0] expDiv(input logic wide);
    return wide ? ssp_pkg::BIT_DIV_WIDE : ssp_pkg::BIT_DIV_HIGH_BW;
  endfunction : expDiv

  task automatic chkStraps(input logic ep, input logic es, input logic ew, input logic ef);
    chk("twoWireMode", {31'h0, ep}, {31'h0, twoWireMode});
    chk("spreadOn", {31'h0, es}, {31'h0, spreadOn});
    chk("strapFault", {31'h0, ef}, {31'h0, strapFault});
    if (!ef)
    begin
      chk("wideMode", {31'h0, ew}, {31'h0, wideMode});
      chk("bitDivisor", {26'h0, expDiv(ew)}, {26'h0, bitDivisor});
    end
  endtask : chkStraps

  task automatic irqStep(input logic n, input logic r, input logic e);
    irqNewData = n;
    irqRegRead = r;
    mc(1);
    irqNewData = 1'b0;
    irqRegRead = 1'b0;
    mc(1);
    chk("irqPendingOut", {31'h0, e}, {31'h0, irqPendingOut});
  endtask : irqStep

  initial
  begin
    #200000;
    errTotal = errTotal + 1;
    $display("Error watchdog expected finish seen hang");
    endSim();
  end

  initial
  begin
    seed = 32'h34e9af9c;
    errTotal = 0;
    checked = 0;
    {rst, powerDown_n, ctrlProtocolStrap} = 3'h7;
    {spreadEnableStrap, busWidthHigh, busWidthLow, dataRateSelect, audioEncodeEn} = 5'h00;
    {cryptEn, audioExternal, videoWord, cryptMask} = {2'h3, 64'h0};
    {auxControlInA, auxControlInB, srcControlSel, irqNewData, irqRegRead} = 5'h00;
    {srcControlA, srcControlB} = 2'h0;
    {recAudioData, recBitClk, recWordSel, audioDataIn, bitClkIn, wordSelIn} = 6'h00;
    {ddcSdaDriveLow, srcRun, srcSdaLow} = 3'h0;
    mc(16);
    rst = 1'b0;
    mc(6);
    chkStraps(1'b1, 1'b0, 1'b0, 1'b0);
    chk("lowRate", 32'h0, {31'h0, lowRate});
    $display("test reset done");
    // Straps taken only at wake; later pin changes ignored
    for (i = 0; i < 6; i++)
    begin
      p = 1'($random(seed));
      s = 1'($random(seed));
      {ctrlProtocolStrap, spreadEnableStrap} = {p, s};
      {busWidthHigh, busWidthLow} = {i % 3 == 1, i % 3 == 2};
      dataRateSelect = 1'($random(seed));
      powerDown_n = 1'b0;
      mc(6);
      powerDown_n = 1'b1;
      mc(10);
      {ctrlProtocolStrap, spreadEnableStrap, busWidthHigh, busWidthLow} = {!p, !s, 2'h0};
      mc(10);
      chkStraps(p, s, i % 3 == 1, i % 3 == 2);
      chk("lowRate", {31'h0, dataRateSelect}, {31'h0, lowRate});
    end
    $display("test straps done");
    for (j = 0; j < 2; j++)
    begin
      cryptEn = j[0];
      repeat (6) @(negedge pixClk);
      for (i = 0; i < 20; i++)
      begin
        {videoWord, cryptMask} = {$random(seed), $random(seed)};
        {auxControlInA, auxControlInB, audioDataIn, srcControlSel} = 4'($random(seed));
        {srcControlA, srcControlB} = 2'($random(seed));
        expW = videoWord ^ (j[0] ? cryptMask : 32'h0);
        expW[29] = audioDataIn;
        expW[28] = srcControlSel ? srcControlB : auxControlInB;
        expW[27] = srcControlSel ? srcControlA : auxControlInA;
        @(negedge pixClk);
        chk("serialWord", expW, serialWord);
      end
    end
    $display("test side bits done");
    audioEncodeEn = 1'b1;
    for (j = 0; j < 2; j++)
    begin
      audioExternal = j[0];
      {recAudioData, recBitClk, recWordSel} = 3'($random(seed));
      repeat (5) @(negedge pixClk);
      chk("audioDataOe_n", j, {31'h0, audioDataOe_n});
      chk("bitClkOe_n", j, {31'h0, bitClkOe_n});
      chk("wordSelOe_n", j, {31'h0, wordSelOe_n});
      chk("audioBit", {31'h0, (j ? audioDataIn : recAudioData) ^ cryptMask[29]},
        {31'h0, serialWord[29]});
      if (j == 0)
        chk("audioOuts", {29'h0, recAudioData, recBitClk, recWordSel},
          {29'h0, audioDataOut, bitClkOut, wordSelOut});
    end
    $display("test audio pins done");
    mc(2);
    irqStep(1'b1, 1'b0, 1'b1);
    irqStep(1'b0, 1'b0, 1'b1);
    irqStep(1'b1, 1'b1, 1'b1);
    irqStep(1'b0, 1'b1, 1'b0);
    irqStep(1'b1, 1'b0, 1'b1);
    irqStep(1'b0, 1'b1, 1'b0);
    $display("test interrupt done");
    chk("ddcSclSeen", 32'h1, {31'h0, ddcSclSeen});
    chk("sclOe_n", 32'h1, {31'h0, displayDataSclOe_n});
    srcSdaLow = 1'b1;
    mc(6);
    chk("ddcSdaSeen", 32'h0, {31'h0, ddcSdaSeen});
    {srcSdaLow, ddcSdaDriveLow} = 2'h1;
    mc(6);
    chk("sdaWire", 32'h0, {31'h0, displayDataSdaIn});
    ddcSdaDriveLow = 1'b0;
    mc(6);
    chk("sdaWire", 32'h1, {31'h0, displayDataSdaIn});
    srcRun = 1'b1;
    mc(260);
    chk("ddcSclSeen", 32'h0, {31'h0, ddcSclSeen});
    srcRun = 1'b0;
    mc(6);
    chk("ddcSclSeen", 32'h1, {31'h0, ddcSclSeen});
    $display("test display channel done");
    endSim();
  end
endmodule : ssp_strap_side_tb_top
